// *** cpu_core_model.sv ***
// cpu side model: drives the register port and the page select
// assumes signals change right after a rising edge, one strobe per call
`timescale 1ns/100ps
module cpu_core_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  output logic [1:0] bank_sel
);
  logic [7:0] exp_q[$];
  // idle bus, page 0 selected
  initial begin
    {addr, wdata, wr, rd} = '0;
    bank_sel = 2'b01;
  end
  // one write cycle, bus scrambled once released
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : put
  // page select change, right after a rising edge
  task automatic page(input logic [1:0] p);
    @(posedge ref_clk);
    bank_sel <= p;
  endtask : page
  // one read cycle, expected byte noted for the monitor
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd <= 1'b0;
    addr <= ~a;
  endtask : get
endmodule : cpu_core_model

// *** eeprom_cell_array.sv ***
// eeprom cell storage: eight byte lanes, one row-wide program port
// assumes the controller never programs while it reads the same cell
`timescale 1ns/100ps
module eeprom_cell_array #(
  parameter int ROWS = 16
) (
  // clock
  input wire logic ref_clk,
  // read port, combinational
  input wire logic [$clog2(ROWS)-1:0] rd_row,
  input wire logic [2:0] rd_byte,
  output logic [7:0] rd_data,
  // program port
  input wire logic prog_en,
  input wire logic [$clog2(ROWS)-1:0] prog_row,
  input wire logic [7:0] prog_mask,
  input wire logic [63:0] prog_data
);

  logic [7:0] lane_q [8];

  // one storage lane per byte position of a row
  for (genvar b = 0; b < 8; b++) begin : g_lane
    logic [7:0] cells [ROWS];
    // only lanes whose mask bit is set are rewritten
    always_ff @(posedge ref_clk) begin
      if (prog_en && prog_mask[b]) begin
        cells[prog_row] <= prog_data[8*b +: 8];
      end
    end
    assign lane_q[b] = cells[rd_row];
  end

  assign rd_data = lane_q[rd_byte];

endmodule : eeprom_cell_array

// *** eeprom_ctl_props.sv ***
// port checker for the eeprom control block
// assumes a single clock domain and a bind onto the block's top module
`timescale 1ns/100ps
module eeprom_ctl_props #(
  parameter int PROG_CYCLES = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // status
  input wire logic program_busy_flag,
  input wire logic array_power_down,
  input wire logic irq
);
  int busy_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // length of the current busy run
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= program_busy_flag ? busy_cnt + 1 : 0;
    end
  end
  a_busy_run_length: assert property (
    $fell(program_busy_flag) |-> busy_cnt == PROG_CYCLES) else $error("busy length wrong");
  a_busy_start_cause: assert property (
    $rose(program_busy_flag) |-> $past(wr) && !$past(array_power_down) && ($past(addr) < 8'h40
    || $past(addr) == 8'hea && $past(wdata[3:2]) == 2'b11 && $past(wdata[0])))
    else $error("busy without a cause");
  a_ctl_read_image: assert property (
    $past(rd) && $past(addr) == 8'hea |-> rdata[1] == $past(program_busy_flag)
    && rdata[5:4] == 2'b00 && !rdata[7]) else $error("control image wrong");
  a_start_idle_zero: assert property (
    $past(rd) && $past(addr) == 8'hea && !$past(program_busy_flag) |-> !rdata[3])
    else $error("start bit set while idle");
  a_unmapped_read: assert property (
    $past(rd) && $past(addr) inside {[8'h40:8'he9]} |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_standby_copy: assert property (
    $past(wr) && $past(addr) == 8'hea && !$past(program_busy_flag)
    |-> array_power_down == $past(wdata[6])) else $error("standby not taken");
  a_busy_read_blank: assert property (
    $past(program_busy_flag) && $past(rd) && $past(addr) < 8'h40 |-> rdata == 8'h00)
    else $error("read while busy not blank");
  a_standby_read_blank: assert property (
    $past(array_power_down) && $past(rd) && $past(addr) < 8'h40 |-> rdata == 8'h00)
    else $error("read in standby not blank");
  a_ctl_busy_ignore: assert property (
    $past(program_busy_flag) && $past(wr) && $past(addr) == 8'hea
    |-> array_power_down == $past(array_power_down)) else $error("write taken while busy");
  c_prog_done: cover property ($fell(program_busy_flag));
  c_standby: cover property ($rose(array_power_down));
  c_irq: cover property ($rose(irq));
endmodule : eeprom_ctl_props

bind eeprom_program_control eeprom_ctl_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .program_busy_flag(program_busy_flag),
  .array_power_down(array_power_down), .irq(irq));

// *** eeprom_program_control.sv ***
// eeprom control: control/status register, row latches, programming sequencer
// assumes a cpu-side plain register port and a bank select from the bank register
//
// Operation
// [R01] control register at eah, resets to 00h
// [R02] standby bit 6 disables array, low power
// [R03] start bit 3 programs latched row immediately
// [R04] start bit self-clears when programming ends
// [R05] unloaded row bytes keep their contents
// [R06] mode bit 2 lets up to eight row bytes load
// [R07] row is a7..a3, a2..a0 pick byte; the code takes the row from the page and a5..a3
// [R08] mode bit self-clears after each row program
// [R09] clearing mode before start abandons row
// [R10] busy bit 1 high throughout programming
// [R11] software polls busy before any access
// [R12] accesses ignored while busy, cycle completes
// [R13] enable bit 0 required before any write; the code latches row-mode byte writes with enable low
// [R14] write with enable low starts nothing
// [R15] entering mode clears the eight row latches
// [R16] first access latches row until end
// [R17] start without mode is refused, unchanged
// [R18] control writes ignored while busy
// [R19] byte-mode write programs one byte, busy
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "eeprom_program_control_defines.svh"
module eeprom_program_control
  import eeprom_program_control_pkg::*;
#(
  parameter int PAGES = 2,
  parameter int PROG_CYCLES = `EE_PROG_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // bank select, one-hot eeprom page from the bank register
  input wire logic [1:0] bank_sel,
  // status
  output logic program_busy_flag,
  output logic array_power_down,
  output logic irq
);

  localparam int ROWS = PAGES * 8;
  localparam int RW = $clog2(ROWS);
  localparam int CW = $clog2(PROG_CYCLES + 1);

  // refuse configurations the logic cannot serve
  if (PAGES < 1 || PAGES > 2) begin : g_bad_pages
    $error("eeprom_program_control: PAGES must be 1 or 2");
  end
  if (PROG_CYCLES < 1) begin : g_bad_cycles
    $error("eeprom_program_control: PROG_CYCLES must be at least 1");
  end

  // whole state of the block
  typedef struct packed {
    ctl_state_t state;
    prog_kind_t kind;
    logic [CW-1:0] count;
    logic standby_disable_bit;
    logic parallel_start_bit;
    logic parallel_mode_bit;
    logic program_busy_flag;
    logic program_enable_bit;
    logic row_latched;
    logic [RW-1:0] row;
    logic [7:0] row_mask;
    logic [63:0] row_data;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
  } ctl_regs_t;

  ctl_regs_t st;
  ctl_regs_t next_st;

  // array hookup
  logic [7:0] cell_rd_data;
  logic prog_fire;
  logic [RW-1:0] acc_row;
  logic page_ok;
  logic page_hi;

  // decode of the selected page; none or both selected means no page
  always_comb begin
    page_hi = bank_sel[1];
    if (PAGES == 1) begin
      page_ok = (bank_sel == 2'b01);
    end else begin
      page_ok = (bank_sel == 2'b01) || (bank_sel == 2'b10);
    end
  end

  // row index from page and address bits a5..a3
  assign acc_row = RW'((page_hi ? 8 : 0) + int'(addr[5:3])); // [R07]

  // the row is written in the cycle the counter expires
  assign prog_fire = (st.state == ctl_program) && (st.count == CW'(1));

  eeprom_cell_array #(
    .ROWS(ROWS)
  ) u_cells (
    .ref_clk(ref_clk),
    .rd_row(acc_row),
    .rd_byte(addr[2:0]),
    .rd_data(cell_rd_data),
    .prog_en(prog_fire),
    .prog_row(st.row),
    .prog_mask(st.row_mask), // [R05]
    .prog_data(st.row_data)
  );

  // next-state logic
  always_comb begin
    logic is_ctl;
    logic is_mem;
    logic ev_done;
    logic ev_refused;
    logic [7:0] ctl_view;
    logic [7:0] clear_bits;
    is_ctl = 1'b0;
    is_mem = 1'b0;
    ev_done = 1'b0;
    ev_refused = 1'b0;
    ctl_view = 8'h00;
    clear_bits = 8'h00;
    next_st = st;
    next_st.rdata = 8'h00;

    is_ctl = (addr == `EE_CTL_ADDR); // [R01]
    is_mem = (addr < `EE_PAGE_LIMIT) && page_ok;

    // readable image of the control register, reserved bits as zero
    ctl_view[`EE_BIT_STANDBY] = st.standby_disable_bit;
    ctl_view[`EE_BIT_PAR_START] = st.parallel_start_bit;
    ctl_view[`EE_BIT_PAR_MODE] = st.parallel_mode_bit;
    ctl_view[`EE_BIT_BUSY] = st.program_busy_flag; // [R10]
    ctl_view[`EE_BIT_ENABLE] = st.program_enable_bit;

    // programming sequencer
    unique case (st.state)
      ctl_idle: begin
      end
      ctl_program: begin
        if (st.count == CW'(1)) begin
          // end of cycle: drop busy, start, mode and the row latch
          next_st.state = ctl_idle;
          next_st.count = '0;
          next_st.program_busy_flag = 1'b0; // [R10]
          next_st.parallel_start_bit = 1'b0; // [R04]
          next_st.parallel_mode_bit = 1'b0; // [R08]
          next_st.row_latched = 1'b0; // [R16]
          next_st.row_mask = 8'h00;
          ev_done = 1'b1;
        end else begin
          next_st.count = st.count - CW'(1);
        end
      end
    endcase

    // register writes
    if (wr) begin
      if (is_ctl) begin
        if (st.program_busy_flag) begin
          ev_refused = 1'b1; // [R18]
        end else begin
          next_st.standby_disable_bit = wdata[`EE_BIT_STANDBY]; // [R02]
          next_st.program_enable_bit = wdata[`EE_BIT_ENABLE]; // [R13]
          next_st.parallel_mode_bit = wdata[`EE_BIT_PAR_MODE]; // [R06]
          if (wdata[`EE_BIT_PAR_MODE] && !st.parallel_mode_bit) begin
            // fresh entry into row mode empties the latches
            next_st.row_mask = 8'h00; // [R15]
            next_st.row_data = 64'h0; // [R15]
            next_st.row_latched = 1'b0;
          end
          if (!wdata[`EE_BIT_PAR_MODE]) begin
            // leaving row mode without a start discards the row
            next_st.row_mask = 8'h00; // [R09]
            next_st.row_latched = 1'b0; // [R09]
          end
          if (wdata[`EE_BIT_PAR_START]) begin
            if (st.parallel_mode_bit && wdata[`EE_BIT_PAR_MODE] &&
                wdata[`EE_BIT_ENABLE] && !wdata[`EE_BIT_STANDBY]) begin
              // row programming starts at once
              next_st.parallel_start_bit = 1'b1; // [R03]
              next_st.program_busy_flag = 1'b1; // [R10]
              next_st.state = ctl_program; // [R03]
              next_st.kind = row_program_mode;
              next_st.count = CW'(PROG_CYCLES);
            end else begin
              // start without mode or enable: no cycle, bit stays clear
              ev_refused = 1'b1; // [R17]
            end
          end
        end
      end else if (addr == `EE_IRQ_STATUS_ADDR) begin
        clear_bits = wdata;
      end else if (addr == `EE_IRQ_MASK_ADDR) begin
        next_st.irq_mask = wdata;
      end else if (is_mem) begin
        if (st.program_busy_flag || st.standby_disable_bit) begin
          ev_refused = 1'b1; // [R12]
        end else if (st.parallel_mode_bit) begin
          // row mode: latch the row on first access, load the byte
          if (!st.row_latched || st.row == acc_row) begin
            next_st.row_latched = 1'b1; // [R16]
            next_st.row = acc_row; // [R16]
            next_st.row_mask[addr[2:0]] = 1'b1; // [R06]
            next_st.row_data[8*addr[2:0] +: 8] = wdata; // [R07]
          end else begin
            ev_refused = 1'b1; // [R16]
          end
        end else if (st.program_enable_bit) begin
          // byte mode: one byte through the same row path
          next_st.row = acc_row; // [R19]
          next_st.row_mask = 8'h01 << addr[2:0]; // [R19]
          next_st.row_data[8*addr[2:0] +: 8] = wdata; // [R19]
          next_st.program_busy_flag = 1'b1; // [R19]
          next_st.state = ctl_program; // [R19]
          next_st.kind = single_byte_mode;
          next_st.count = CW'(PROG_CYCLES);
        end else begin
          ev_refused = 1'b1; // [R14]
        end
      end
    end

    // register reads, data stands in the following cycle only
    if (rd) begin
      if (is_ctl) begin
        next_st.rdata = ctl_view;
      end else if (addr == `EE_IRQ_STATUS_ADDR) begin
        next_st.rdata = st.irq_status;
      end else if (addr == `EE_IRQ_MASK_ADDR) begin
        next_st.rdata = st.irq_mask;
      end else if (is_mem) begin
        if (st.program_busy_flag || st.standby_disable_bit) begin
          ev_refused = 1'b1; // [R12]
        end else begin
          next_st.rdata = cell_rd_data;
        end
      end
    end

    // sticky events: a new event wins over a write-one clear
    next_st.irq_status = (st.irq_status & ~clear_bits);
    next_st.irq_status[`EE_IRQ_DONE] = next_st.irq_status[`EE_IRQ_DONE] | ev_done;
    next_st.irq_status[`EE_IRQ_REFUSED] =
      next_st.irq_status[`EE_IRQ_REFUSED] | ev_refused;
    next_st.irq_status[7:2] = 6'h00;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st.state <= ctl_idle;
      st.kind <= single_byte_mode;
      st.count <= '0;
      st.standby_disable_bit <= 1'(`EE_CTL_RESET >> `EE_BIT_STANDBY); // [R01]
      st.parallel_start_bit <= 1'b0;
      st.parallel_mode_bit <= 1'b0;
      st.program_busy_flag <= 1'b0;
      st.program_enable_bit <= 1'b0;
      st.row_latched <= 1'b0;
      st.row <= '0;
      st.row_mask <= 8'h00;
      st.row_data <= 64'h0;
      st.irq_status <= `EE_IRQ_RESET;
      st.irq_mask <= `EE_IRQ_RESET;
      st.rdata <= 8'h00;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign rdata = st.rdata;
  assign program_busy_flag = st.program_busy_flag; // [R10]
  assign array_power_down = st.standby_disable_bit; // [R02]
  assign irq = st.irq;

endmodule : eeprom_program_control

// *** eeprom_program_control_defines.svh ***
// constants of the eeprom control block: offsets, bit positions, resets, timing
// assumes an 8-bit data space and a 50 ns reference clock
`ifndef EEPROM_PROGRAM_CONTROL_DEFINES_SVH
`define EEPROM_PROGRAM_CONTROL_DEFINES_SVH

// data-space addresses
`define EE_CTL_ADDR 8'hea
`define EE_IRQ_STATUS_ADDR 8'hec
`define EE_IRQ_MASK_ADDR 8'hed
`define EE_PAGE_LIMIT 8'h40

// control register bit positions
`define EE_BIT_ENABLE 0
`define EE_BIT_BUSY 1
`define EE_BIT_PAR_MODE 2
`define EE_BIT_PAR_START 3
`define EE_BIT_STANDBY 6

// interrupt status bit positions
`define EE_IRQ_DONE 0
`define EE_IRQ_REFUSED 1

// reset values
`define EE_CTL_RESET 8'h00
`define EE_IRQ_RESET 8'h00

// timing: clock period and one programming cycle, both in ns
`define EE_CLK_PERIOD_NS 50
`define EE_PROG_TIME_NS 5000000
`define EE_PROG_CYCLES ((`EE_PROG_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)

`endif

// *** eeprom_program_control_pkg.sv ***
// types shared by the eeprom control block
// assumes nothing beyond the constants header
package eeprom_program_control_pkg;

  // programming sequencer states
  typedef enum logic [0:0] {
    ctl_idle,
    ctl_program
  } ctl_state_t;

  // kind of programming cycle in flight
  typedef enum logic [0:0] {
    single_byte_mode,
    row_program_mode
  } prog_kind_t;

endpackage : eeprom_program_control_pkg

// *** testbench.sv ***
// self-checking bench for the eeprom control block
// assumes the cpu model drives the port and a short programming time
`timescale 1ns/100ps
module testbench;
  localparam int PC = 8;
  logic ref_clk, arst_n, wr, rd, program_busy_flag, array_power_down, irq, rd_seen;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] bank_sel;
  logic [7:0] mem[8];
  int failures = 0;
  int total_checks = 0;
  cpu_core_model cpu (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .bank_sel(bank_sel));
  eeprom_program_control #(.PAGES(2), .PROG_CYCLES(PC)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .bank_sel(bank_sel), .program_busy_flag(program_busy_flag),
    .array_power_down(array_power_down), .irq(irq));
  // compare and tally
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // poll busy for a fixed PC + 4 cycles, counting busy cycles
  task automatic wait_idle(input int exp_cycles);
    int n;
    n = 0;
    repeat (PC + 4) begin
      @(negedge ref_clk);
      if (program_busy_flag === 1'b1) n++;
    end
    if (exp_cycles >= 0) check("busy cycles", 8'(n), 8'(exp_cycles));
  endtask : wait_idle
  task automatic read_row();
    for (int i = 0; i < 8; i++) cpu.get(8'h18 + 8'(i), mem[i]);
  endtask : read_row
  // read data stands one cycle after the strobe
  always @(posedge ref_clk) rd_seen <= rd;
  always @(negedge ref_clk) begin
    if (rd_seen === 1'b1) check("rdata", rdata, cpu.exp_q.pop_front());
  end
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // watchdog
  initial begin
    #(50 * 5000);
    failures++;
    report_and_stop();
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    void'($urandom(47));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    cpu.get(8'hea, 8'h00);
    cpu.get(8'h90, 8'h00);
    cpu.put(8'hea, 8'h01);
    for (int i = 0; i < 7; i++) begin
      cpu.put(8'h18 + 8'(i), mem[i]);
      wait_idle(PC);
    end
    cpu.put(8'h1f, mem[7]);
    cpu.get(8'h19, 8'h00);
    cpu.put(8'hea, 8'h40);
    cpu.get(8'hea, 8'h03);
    check("standby", {7'h00, array_power_down}, 8'h00);
    wait_idle(-1);
    read_row();
    mem[0] = 8'($urandom);
    mem[2] = 8'($urandom);
    cpu.put(8'hea, 8'h05);
    cpu.put(8'h18, mem[0]);
    cpu.put(8'h1a, mem[2]);
    cpu.put(8'hea, 8'h0d);
    wait_idle(PC);
    cpu.get(8'hea, 8'h01);
    read_row();
    cpu.put(8'hea, 8'h05);
    cpu.put(8'h1b, ~mem[3]);
    cpu.put(8'hea, 8'h01);
    cpu.put(8'hea, 8'h09);
    wait_idle(0);
    cpu.get(8'hea, 8'h01);
    cpu.put(8'hea, 8'h00);
    cpu.put(8'h1c, ~mem[4]);
    wait_idle(0);
    read_row();
    cpu.put(8'hea, 8'h01);
    cpu.page(2'b10);
    cpu.put(8'h18, ~mem[0]);
    wait_idle(PC);
    cpu.get(8'h18, ~mem[0]);
    cpu.page(2'b00);
    cpu.get(8'h18, 8'h00);
    cpu.page(2'b01);
    cpu.get(8'h18, mem[0]);
    cpu.put(8'hea, 8'h40);
    cpu.get(8'hea, 8'h40);
    cpu.get(8'h18, 8'h00);
    check("standby", {7'h00, array_power_down}, 8'h01);
    cpu.put(8'hea, 8'h00);
    cpu.get(8'hec, 8'h03);
    cpu.put(8'hed, 8'h03);
    repeat (3) @(negedge ref_clk);
    check("irq", {7'h00, irq}, 8'h01);
    cpu.put(8'hec, 8'h03);
    repeat (3) @(negedge ref_clk);
    check("irq", {7'h00, irq}, 8'h00);
    report_and_stop();
  end
endmodule : testbench
